// *** rtl/bmpg_top.sv ***
// Two-converter mode control with delayed, masked power-good
// Operation
// RQ1: Pulse mode only after 32 light cycles
// RQ2: Light load: discontinuous or low peak current
// RQ3: High side on until high threshold or limit
// RQ4: Low side on until zero current
// RQ5: At high threshold ramp down, then sleep
// RQ6: Leave sleep below low threshold
// RQ7: Below second low threshold return to PWM
// RQ8: Each converter has own external enable
// RQ9: Automatic mode default, factory force PWM
// RQ10: Disabled: high side off, low side on
// RQ11: Soft start on enable rise, supply ok
// RQ12: Current limit steps 250, 500, 950, 2000 mA
// RQ13: Full duty high side on for dropout
// RQ14: Power-good low when outputs not in range
// RQ15: Delay choice 50us/50/100/200 ms, default 50 ms
// RQ16: Level rise with enable starts delay
// RQ17: Running delay ignores other channel events
// RQ18: Level loss restarts delay, power-good low
// RQ19: Missing second level keeps power-good low
// RQ20: Late enable starts 5 ms high mask
// RQ21: Level still low after mask: low
// RQ22: Delay timer reset and set exclusive
// RQ23: Mask timers gated, outputs ANDed
// RQ24: Supply ok gates all four enables
// RQ25: System keeps converters off at power-up
// RQ26: Timers count oscillator cycles
module bmpg_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] dly_sel_in,
  input wire logic force_pwm_in,
  input wire logic supply_ok_in,
  input wire logic buck_one_enable_in,
  input wire logic buck_two_enable_in,
  input wire logic ldo_one_enable_in,
  input wire logic ldo_two_enable_in,
  input wire logic buck_one_level_ok_in,
  input wire logic buck_two_level_ok_in,
  input wire logic [1:0] full_on_req_in,
  input wire logic [1:0] discontinuous_in,
  input wire logic [1:0] below_mode_current_in,
  input wire logic [1:0] above_high_in,
  input wire logic [1:0] below_low_in,
  input wire logic [1:0] below_low2_in,
  input wire logic [1:0] pulse_peak_current_limit_in,
  input wire logic [1:0] zero_current_in,
  input wire logic [1:0] pwm_hs_in,
  output logic [1:0] hs_on_out,
  output logic [1:0] ls_on_out,
  output logic [3:0] ilim_step_out,
  output logic [1:0] pfm_active_out,
  output logic [1:0] ldo_enable_out,
  output logic power_good_n_out,
  output logic power_good_n_oe_out
);
  logic [1:0] en_g;
  logic [1:0] rdy;
  logic [1:0] en_d_r;
  logic [1:0] rdy_d_r;
  logic [1:0] dly_sel_r;
  logic dly_run_r;
  logic dly_done_r;
  logic [bmpg_pkg::CNT_W-1:0] dly_cnt_r;
  logic [1:0] mask_run_r;
  logic [bmpg_pkg::CNT_W-1:0] mask_cnt_r [2];
  logic [1:0] ch_good;
  logic dly_set;
  logic dly_clr;

  function automatic logic [bmpg_pkg::CNT_W-1:0] dly_term(input logic [1:0] sel);
    unique case (sel)
      2'h0: dly_term = bmpg_pkg::CNT_W'(bmpg_pkg::DLY0_CYC - 1);
      2'h1: dly_term = bmpg_pkg::CNT_W'(bmpg_pkg::DLY1_CYC - 1);
      2'h2: dly_term = bmpg_pkg::CNT_W'(bmpg_pkg::DLY2_CYC - 1);
      default: dly_term = bmpg_pkg::CNT_W'(bmpg_pkg::DLY3_CYC - 1);
    endcase
  endfunction

  // RQ24 supply gates enables
  assign en_g = {buck_two_enable_in, buck_one_enable_in} & {2{supply_ok_in}};
  assign rdy = {buck_two_level_ok_in, buck_one_level_ok_in};

  // RQ15 delay select latched
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dly_sel_r <= bmpg_pkg::DLY_SEL_RST;
    end else if (en_g == 2'b00) begin
      dly_sel_r <= dly_sel_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ldo_enable_out <= 2'b00;
      en_d_r <= 2'b00;
      rdy_d_r <= 2'b00;
    end else begin
      ldo_enable_out <= {ldo_two_enable_in, ldo_one_enable_in} & {2{supply_ok_in}};
      en_d_r <= en_g;
      rdy_d_r <= rdy;
    end
  end

  // RQ16 set on level rise under enable; RQ18 also on level loss
  assign dly_set = (|(en_g & rdy & ~rdy_d_r) && !dly_done_r)
      || |(en_d_r & rdy_d_r & ~rdy);
  // RQ22 clear only when no set
  assign dly_clr = (en_g == 2'b00) && !dly_set;

  // RQ26 delay counter
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || dly_clr) begin
      dly_run_r <= 1'b0;
      dly_done_r <= 1'b0;
      dly_cnt_r <= '0;
    // RQ17 running count ignores others
    end else if (dly_set && !(dly_run_r && !(|(en_d_r & rdy_d_r & ~rdy)))) begin
      dly_run_r <= 1'b1;
      dly_done_r <= 1'b0;
      dly_cnt_r <= '0;
    end else if (dly_run_r) begin
      if (dly_cnt_r == dly_term(dly_sel_r)) begin
        dly_run_r <= 1'b0;
        dly_done_r <= 1'b1;
      end else begin
        dly_cnt_r <= dly_cnt_r + 1'b1;
      end
    end
  end

  // RQ20 mask windows on late enable
  for (genvar i = 0; i < 2; i++) begin : g_mask
    always_ff @(posedge clk_in) begin
      if (!rst_n_in || !en_g[i]) begin
        mask_run_r[i] <= 1'b0;
        mask_cnt_r[i] <= '0;
      end else if (en_g[i] && !en_d_r[i] && dly_done_r) begin
        mask_run_r[i] <= 1'b1;
        mask_cnt_r[i] <= '0;
      end else if (mask_run_r[i]) begin
        if (mask_cnt_r[i] == bmpg_pkg::CNT_W'(bmpg_pkg::MASK_CYC - 1)) begin
          mask_run_r[i] <= 1'b0;
        end else begin
          mask_cnt_r[i] <= mask_cnt_r[i] + 1'b1;
        end
      end
    end
    // RQ23 per channel gated term; RQ21 low level after mask fails
    // Late enable good before mask flop is set
    assign ch_good[i] = mask_run_r[i] || (en_g[i] && !en_d_r[i] && dly_done_r) || rdy[i]
        || (!en_g[i] && !rdy[i] && en_g != 2'b00);
  end

  // RQ14 open drain power good; RQ19 missing level holds low
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      power_good_n_out <= 1'b0;
      power_good_n_oe_out <= 1'b1;
    end else begin
      power_good_n_out <= 1'b0;
      power_good_n_oe_out <= !(dly_done_r && !dly_set && (&ch_good));
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    bmpg_channel u_ch (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .enable_in(en_g[c]),
      .force_pwm_in(force_pwm_in),
      .full_on_req_in(full_on_req_in[c]),
      .discontinuous_in(discontinuous_in[c]),
      .below_mode_current_in(below_mode_current_in[c]),
      .above_high_in(above_high_in[c]),
      .below_low_in(below_low_in[c]),
      .below_low2_in(below_low2_in[c]),
      .peak_over_limit_in(pulse_peak_current_limit_in[c]),
      .zero_current_in(zero_current_in[c]),
      .pwm_hs_in(pwm_hs_in[c]),
      .hs_on_out(hs_on_out[c]),
      .ls_on_out(ls_on_out[c]),
      .ilim_step_out(ilim_step_out[2*c+1:2*c]),
      .pfm_active_out(pfm_active_out[c])
    );
  end

  // RQ18 level loss pulls low
  a_level_loss: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      |(en_d_r & rdy_d_r & ~rdy) |=> power_good_n_oe_out)
    else $error("power good stayed high after level loss");
  // RQ16 held low while counting
  a_dly_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      dly_run_r |=> power_good_n_oe_out)
    else $error("power good released during delay");
  // RQ22 exclusive set and clear
  a_set_clr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(dly_set && dly_clr))
    else $error("delay set and clear together");
  // RQ22 clear empties the timer
  a_clr_effect: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      dly_clr |=> !dly_run_r && !dly_done_r)
    else $error("delay timer not cleared");
  // RQ24 supply gating
  a_uvlo_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !supply_ok_in |=> ldo_enable_out == 2'b00 && ls_on_out == 2'b11 && hs_on_out == 2'b00)
    else $error("regulator active under low supply");
  // RQ20 mask holds high
  a_mask_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (|mask_run_r) && (&(mask_run_r | rdy)) && dly_done_r && !dly_set
      |=> !power_good_n_oe_out)
    else $error("power good low inside mask");
endmodule : bmpg_top

// *** rtl/bmpg_pkg.sv ***
// Shared constants for the buck mode and power-good controller
package bmpg_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned LIGHT_LOAD_CYCLES = 32;
  localparam logic [5:0] LIGHT_CNT_W_MAX = 6'h20;
  // Delay choices, in microseconds
  localparam int unsigned DLY0_US = 50;
  localparam int unsigned DLY1_US = 50_000;
  localparam int unsigned DLY2_US = 100_000;
  localparam int unsigned DLY3_US = 200_000;
  localparam int unsigned MASK_US = 5_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned DLY0_CYC = DLY0_US * CYC_PER_US;
  localparam int unsigned DLY1_CYC = DLY1_US * CYC_PER_US;
  localparam int unsigned DLY2_CYC = DLY2_US * CYC_PER_US;
  localparam int unsigned DLY3_CYC = DLY3_US * CYC_PER_US;
  localparam int unsigned MASK_CYC = MASK_US * CYC_PER_US;
  localparam logic [1:0] DLY_SEL_RST = 2'h1;
  // Soft-start current limit steps, code 0..3 = 250 mA, 500 mA, 950 mA, 2 A
  localparam logic [1:0] ILIM_STEP_250MA = 2'h0;
  localparam logic [1:0] ILIM_STEP_2A = 2'h3;
  localparam int unsigned SS_STEP_US = 100;
  localparam int unsigned SS_STEP_CYC = SS_STEP_US * CYC_PER_US;
  localparam int unsigned CNT_W = 23;

  typedef enum logic [2:0] {
    BMPG_OFF = 3'b000,
    BMPG_PWM = 3'b001,
    BMPG_PFM_HS = 3'b011,
    BMPG_PFM_LS = 3'b010,
    BMPG_PFM_END = 3'b110,
    BMPG_SLEEP = 3'b111,
    BMPG_FULL_ON = 3'b101
  } bmpg_state_e;
endpackage : bmpg_pkg

// *** rtl/bmpg_channel.sv ***
// One step-down converter: mode machine, shutdown and soft start
module bmpg_channel (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic force_pwm_in,
  input wire logic full_on_req_in,
  input wire logic discontinuous_in,
  input wire logic below_mode_current_in,
  input wire logic above_high_in,
  input wire logic below_low_in,
  input wire logic below_low2_in,
  input wire logic peak_over_limit_in,
  input wire logic zero_current_in,
  input wire logic pwm_hs_in,
  output logic hs_on_out,
  output logic ls_on_out,
  output logic [1:0] ilim_step_out,
  output logic pfm_active_out
);
  bmpg_pkg::bmpg_state_e state_r;
  bmpg_pkg::bmpg_state_e state_nxt;
  logic [5:0] light_cnt_r;
  logic [15:0] ss_cnt_r;
  logic en_d_r;
  logic light;

  // RQ2 light load qualifiers
  assign light = discontinuous_in | below_mode_current_in;

  // RQ1 light load persistence
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !light || state_r != bmpg_pkg::BMPG_PWM) begin
      light_cnt_r <= 6'h00;
    end else if (light_cnt_r != bmpg_pkg::LIGHT_CNT_W_MAX) begin
      light_cnt_r <= light_cnt_r + 6'h01;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bmpg_pkg::BMPG_OFF: if (enable_in) state_nxt = bmpg_pkg::BMPG_PWM;
      bmpg_pkg::BMPG_PWM: begin
        // RQ13 low dropout hold
        if (full_on_req_in) begin
          state_nxt = bmpg_pkg::BMPG_FULL_ON;
        // RQ9 forced pwm option
        end else if (!force_pwm_in && light_cnt_r == bmpg_pkg::LIGHT_CNT_W_MAX) begin
          state_nxt = bmpg_pkg::BMPG_PFM_HS;
        end
      end
      bmpg_pkg::BMPG_FULL_ON: if (!full_on_req_in) state_nxt = bmpg_pkg::BMPG_PWM;
      // RQ3 high side pulse
      bmpg_pkg::BMPG_PFM_HS: begin
        if (above_high_in) state_nxt = bmpg_pkg::BMPG_PFM_END;
        else if (peak_over_limit_in) state_nxt = bmpg_pkg::BMPG_PFM_LS;
      end
      // RQ4 low side until zero
      bmpg_pkg::BMPG_PFM_LS: begin
        if (zero_current_in && above_high_in) state_nxt = bmpg_pkg::BMPG_SLEEP;
        else if (zero_current_in) state_nxt = bmpg_pkg::BMPG_PFM_HS;
      end
      // RQ5 ramp to zero then sleep
      bmpg_pkg::BMPG_PFM_END: if (zero_current_in) state_nxt = bmpg_pkg::BMPG_SLEEP;
      // RQ6 restart below low
      bmpg_pkg::BMPG_SLEEP: if (below_low_in) state_nxt = bmpg_pkg::BMPG_PFM_HS;
      default: state_nxt = bmpg_pkg::BMPG_OFF;
    endcase
    // RQ7 fall back to pwm
    if (below_low2_in && (state_r == bmpg_pkg::BMPG_PFM_HS || state_r == bmpg_pkg::BMPG_PFM_LS
        || state_r == bmpg_pkg::BMPG_PFM_END || state_r == bmpg_pkg::BMPG_SLEEP)) begin
      state_nxt = bmpg_pkg::BMPG_PWM;
    end
    if (force_pwm_in && state_r != bmpg_pkg::BMPG_OFF && state_r != bmpg_pkg::BMPG_FULL_ON) begin
      state_nxt = bmpg_pkg::BMPG_PWM;
    end
    // RQ10 disable shuts down
    if (!enable_in) state_nxt = bmpg_pkg::BMPG_OFF;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= bmpg_pkg::BMPG_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // RQ11 soft start on enable edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_d_r <= 1'b0;
      ss_cnt_r <= 16'h0000;
      ilim_step_out <= bmpg_pkg::ILIM_STEP_250MA;
    end else begin
      en_d_r <= enable_in;
      if (enable_in && !en_d_r) begin
        ss_cnt_r <= 16'h0000;
        ilim_step_out <= bmpg_pkg::ILIM_STEP_250MA;
      // RQ12 current limit steps
      end else if (enable_in && ilim_step_out != bmpg_pkg::ILIM_STEP_2A) begin
        if (ss_cnt_r == 16'(bmpg_pkg::SS_STEP_CYC - 1)) begin
          ss_cnt_r <= 16'h0000;
          ilim_step_out <= ilim_step_out + 2'h1;
        end else begin
          ss_cnt_r <= ss_cnt_r + 16'h0001;
        end
      end
    end
  end

  // RQ10 switch drive per state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hs_on_out <= 1'b0;
      ls_on_out <= 1'b1;
      pfm_active_out <= 1'b0;
    end else begin
      unique case (state_nxt)
        bmpg_pkg::BMPG_OFF: begin
          hs_on_out <= 1'b0;
          ls_on_out <= 1'b1;
        end
        bmpg_pkg::BMPG_PWM: begin
          hs_on_out <= pwm_hs_in;
          ls_on_out <= !pwm_hs_in;
        end
        bmpg_pkg::BMPG_FULL_ON, bmpg_pkg::BMPG_PFM_HS: begin
          hs_on_out <= 1'b1;
          ls_on_out <= 1'b0;
        end
        bmpg_pkg::BMPG_PFM_LS, bmpg_pkg::BMPG_PFM_END: begin
          hs_on_out <= 1'b0;
          ls_on_out <= 1'b1;
        end
        default: begin
          hs_on_out <= 1'b0;
          ls_on_out <= 1'b0;
        end
      endcase
      pfm_active_out <= state_nxt == bmpg_pkg::BMPG_PFM_HS || state_nxt == bmpg_pkg::BMPG_PFM_LS
          || state_nxt == bmpg_pkg::BMPG_PFM_END || state_nxt == bmpg_pkg::BMPG_SLEEP;
    end
  end

  // RQ1 light load gate
  a_pfm_entry_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r == bmpg_pkg::BMPG_PWM && state_nxt == bmpg_pkg::BMPG_PFM_HS)
      |-> $past(light) && light_cnt_r == bmpg_pkg::LIGHT_CNT_W_MAX)
    else $error("pfm entered before light load persisted");
  // RQ10 disabled drive
  a_off_discharge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !enable_in |=> !hs_on_out && ls_on_out)
    else $error("disabled converter not discharging");
  // RQ6 sleep restart
  a_sleep_wake: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_r == bmpg_pkg::BMPG_SLEEP && below_low_in && !below_low2_in && enable_in
      && !force_pwm_in |=> hs_on_out)
    else $error("sleep did not restart");
endmodule : bmpg_channel

// *** testbench/bmpg_plant.sv ***
// Behavioural power stage: inductor current per channel
module bmpg_plant (
  input wire logic clk_in,
  input wire logic [1:0] hs_on_in,
  input wire logic [1:0] ls_on_in,
  output logic [1:0] peak_over_out,
  output logic [1:0] zero_current_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cur_r [2] = '{4'h0, 4'h0};
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (hs_on_in[i] && cur_r[i] != 4'h8)
        cur_r[i] <= cur_r[i] + 4'h1;
      else if (ls_on_in[i] && cur_r[i] != 4'h0)
        cur_r[i] <= cur_r[i] - 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      peak_over_out[i] = cur_r[i] >= 4'h4;
      zero_current_out[i] = cur_r[i] == 4'h0;
    end
  end
endmodule // bmpg_plant

// *** testbench/bmpg_top_test.sv ***
// Self-checking bench for the buck mode and power-good controller
module bmpg_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_n_in, force_pwm_in, supply_ok_in;
  logic en1, en2, ldo1, ldo2, lvl1, lvl2;
  logic [1:0] dly_sel_in, full_on, disc, below_mode, above_high, below_low, below_low2, pwm_hs;
  logic [1:0] peak, zero, hs_on, ls_on, pfm, ldo_en;
  logic [3:0] ilim;
  logic pg_n, pg_oe;
  int err_total = 0;
  int compares = 0;

  always #20 clk_in = ~clk_in;

  bmpg_top i_bmpg_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .dly_sel_in(dly_sel_in),
    .force_pwm_in(force_pwm_in), .supply_ok_in(supply_ok_in), .buck_one_enable_in(en1),
    .buck_two_enable_in(en2), .ldo_one_enable_in(ldo1), .ldo_two_enable_in(ldo2),
    .buck_one_level_ok_in(lvl1), .buck_two_level_ok_in(lvl2), .full_on_req_in(full_on),
    .discontinuous_in(disc), .below_mode_current_in(below_mode), .above_high_in(above_high),
    .below_low_in(below_low), .below_low2_in(below_low2),
    .pulse_peak_current_limit_in(peak), .zero_current_in(zero), .pwm_hs_in(pwm_hs),
    .hs_on_out(hs_on), .ls_on_out(ls_on), .ilim_step_out(ilim), .pfm_active_out(pfm),
    .ldo_enable_out(ldo_en), .power_good_n_out(pg_n), .power_good_n_oe_out(pg_oe));

  bmpg_plant i_bmpg_plant (.clk_in(clk_in), .hs_on_in(hs_on), .ls_on_in(ls_on),
    .peak_over_out(peak), .zero_current_out(zero));

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Collects switch activity over a number of cycles
  task automatic watch(input int n, output logic [1:0] hs_any, output logic [1:0] ls_alone);
    hs_any = 2'h0;
    ls_alone = 2'h0;
    repeat (n) begin
      step(1);
      hs_any = hs_any | hs_on;
      ls_alone = ls_alone | (ls_on & ~hs_on);
    end
  endtask

  task automatic do_reset();
    {en1, en2, ldo1, ldo2, lvl1, lvl2} = 6'h00;
    {full_on, disc, below_mode, above_high, below_low, below_low2} = 12'h000;
    force_pwm_in = 1'b0;
    supply_ok_in = 1'b1;
    rst_n_in = 1'b0;
    step(4);
    rst_n_in = 1'b1;
    step(2);
  endtask

  task automatic t_reset();
    do_reset();
    chk("hs", 4'h0, 4'(hs_on));
    chk("ls", 4'h3, 4'(ls_on));
    chk("ilim", 4'h0, ilim);
    chk("pfm", 4'h0, 4'(pfm));
    chk("pg_oe", 4'h1, 4'(pg_oe));
    chk("pg_n", 4'h0, 4'(pg_n));
    $display("test reset done");
  endtask

  task automatic t_supply();
    do_reset();
    supply_ok_in = 1'b0;
    {en1, en2, ldo1, ldo2} = 4'hf;
    step(3);
    chk("ldo_en", 4'h0, 4'(ldo_en));
    chk("ls", 4'h3, 4'(ls_on));
    supply_ok_in = 1'b1;
    step(3);
    chk("ldo_en", 4'h3, 4'(ldo_en));
    $display("test supply done");
  endtask

  task automatic t_soft_start();
    do_reset();
    en1 = 1'b1;
    step(2);
    chk("ilim", 4'h0, ilim);
    step(2600);
    chk("ilim", 4'h1, ilim);
    step(2500);
    chk("ilim", 4'h2, ilim);
    step(2500);
    chk("ilim", 4'h3, ilim);
    step(2500);
    chk("ilim", 4'h3, ilim);
    $display("test soft_start done");
  endtask

  task automatic t_pfm();
    logic [1:0] hs_any, ls_alone;
    do_reset();
    {en1, en2} = 2'h3;
    step(2);
    disc = 2'h1;
    below_mode = 2'h2;
    step(28);
    chk("pfm", 4'h0, 4'(pfm));
    step(12);
    chk("pfm", 4'h3, 4'(pfm));
    {disc, below_mode} = 4'h0;
    watch(16, hs_any, ls_alone);
    chk("pfm_hs", 4'h3, 4'(hs_any));
    chk("pfm_ls", 4'h3, 4'(ls_alone));
    above_high = 2'h3;
    step(20);
    chk("hs", 4'h0, 4'(hs_on));
    chk("ls", 4'h0, 4'(ls_on));
    chk("pfm", 4'h3, 4'(pfm));
    above_high = 2'h0;
    below_low = 2'h3;
    watch(6, hs_any, ls_alone);
    chk("wake_hs", 4'h3, 4'(hs_any));
    below_low = 2'h0;
    below_low2 = 2'h3;
    step(3);
    chk("pfm", 4'h0, 4'(pfm));
    below_low2 = 2'h0;
    force_pwm_in = 1'b1;
    disc = 2'h3;
    step(40);
    chk("pfm", 4'h0, 4'(pfm));
    $display("test pfm done");
  endtask

  task automatic t_full_on();
    do_reset();
    en1 = 1'b1;
    pwm_hs = 2'h1;
    step(2);
    chk("pwm_hs", 4'h1, 4'(hs_on));
    pwm_hs = 2'h0;
    full_on = 2'h1;
    step(3);
    chk("hs", 4'h1, 4'(hs_on[0]));
    chk("ls", 4'h0, 4'(ls_on[0]));
    step(50);
    chk("hs", 4'h1, 4'(hs_on[0]));
    en1 = 1'b0;
    step(3);
    chk("hs", 4'h0, 4'(hs_on));
    chk("ls", 4'h3, 4'(ls_on));
    $display("test full_on done");
  endtask

  task automatic t_pg_delay();
    do_reset();
    {en1, en2} = 2'h3;
    step(2);
    {lvl1, lvl2} = 2'h3;
    step(1200);
    chk("pg_oe", 4'h1, 4'(pg_oe));
    step(100);
    chk("pg_oe", 4'h0, 4'(pg_oe));
    lvl2 = 1'b0;
    step(2);
    chk("pg_oe", 4'h1, 4'(pg_oe));
    lvl2 = 1'b1;
    step(1200);
    chk("pg_oe", 4'h1, 4'(pg_oe));
    step(51);
    chk("pg_oe", 4'h0, 4'(pg_oe));
    $display("test pg_delay done");
  endtask

  task automatic t_pg_missing();
    do_reset();
    {en1, en2} = 2'h3;
    step(2);
    lvl1 = 1'b1;
    step(1400);
    chk("pg_oe", 4'h1, 4'(pg_oe));
    $display("test pg_missing done");
  endtask

  task automatic t_pg_mask();
    do_reset();
    en1 = 1'b1;
    step(2);
    lvl1 = 1'b1;
    step(1300);
    chk("pg_oe", 4'h0, 4'(pg_oe));
    en2 = 1'b1;
    step(1000);
    chk("pg_oe", 4'h0, 4'(pg_oe));
    $display("test pg_mask done");
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end

  initial begin
    rst_n_in = 1'b0;
    dly_sel_in = 2'h0;
    pwm_hs = 2'h0;
    t_reset();
    t_supply();
    t_soft_start();
    t_pfm();
    t_full_on();
    t_pg_delay();
    t_pg_missing();
    t_pg_mask();
    print_verdict();
  end
endmodule // bmpg_top_test
